//--- inc/osd_overlay_pkg.sv
// Constants for the overlay, window, blank and raster logic of the display block.
// Assumes a plain word-addressed register port with 12-bit byte addresses.
`default_nettype none
package osd_overlay_pkg;
	// ==========================================================
	// Register byte addresses
	localparam logic [11:0] ADDR_SPRITE_CTL = 12'h000;
	localparam logic [11:0] ADDR_CTRL1 = 12'h004;
	localparam logic [11:0] ADDR_CTRL2 = 12'h008;
	localparam logic [11:0] ADDR_CTRL3 = 12'h00C;
	localparam logic [11:0] ADDR_TOP = 12'h010;
	localparam logic [11:0] ADDR_BOTTOM = 12'h014;
	localparam logic [11:0] ADDR_LEFT = 12'h018;
	localparam logic [11:0] ADDR_RIGHT = 12'h01C;
	localparam logic [11:0] ADDR_RASTER = 12'h020;
	localparam logic [11:0] ADDR_HPOS1 = 12'h024;
	localparam logic [11:0] ADDR_VPOS1 = 12'h028;
	localparam logic [11:0] ADDR_HPOS2 = 12'h02C;
	localparam logic [11:0] ADDR_VPOS2 = 12'h030;
	localparam logic [11:0] ADDR_PSEL = 12'h034;
	localparam logic [11:0] ADDR_STATUS = 12'h038;
	// Font memory window: base plus index times four
	localparam logic [1:0] FONT_REGION = 2'h1;
	// ==========================================================
	// Field positions
	localparam int SC_EN1 = 0;
	localparam int SC_PREDIV = 1;
	localparam int SC_SIZE_LO = 2;
	localparam int SC_SIZE_HI = 3;
	localparam int SC_EN2 = 4;
	localparam int C1_WIN_REQ = 0;
	localparam int C1_BISCAN = 1;
	localparam int C1_VAREA_ON = 5;
	localparam int C2_HAREA_ON = 4;
	localparam int C2_HBLANK_SEL = 5;
	localparam int C2_VBLANK_SEL = 6;
	localparam int C2_INT_LAYER2 = 7;
	localparam int C3_MODE_LO = 5;
	localparam int ST_BLOCK = 0;
	localparam int ST_OVERLAY = 1;
	// Raster colour word: [2:0] rgb, [3] first aux, [4] second aux, [6:5] level
	localparam int RC_FIRST_AUX_OUTPUT = 3;
	localparam int RC_SECOND_AUX_OUTPUT = 4;
	// ==========================================================
	// Sizes and reset values
	localparam logic [4:0] FONT_ROWS = 5'h14;
	localparam logic [7:0] SPRITE_CTL_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [6:0] RASTER_RESET = 7'h00;
endpackage : osd_overlay_pkg
`default_nettype wire

//--- design/osd_overlay_window_sprite.sv
// Overlay characters, window and blank areas, raster colouring and display interrupts.
// Assumes sync pins from outside the clock domain; block engine signals on ref_clk.
//
// The implementer's own choices: the register addresses and the strobed register port.
`default_nettype none
module osd_overlay_window_sprite (
	input wire logic ref_clk, // 250 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [11:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic hsync_pin, // Horizontal sync, high in sync interval
	input wire logic vsync_pin, // Vertical sync, high in sync interval
	input wire logic blk_active_l1, // Layer 1 block lines being scanned
	input wire logic blk_active_l2, // Layer 2 block lines being scanned
	input wire logic blk_off, // Current block set to off display
	input wire logic [2:0] disp_mode, // One-hot: caption, text, dot mode
	input wire logic char_valid, // Character or background pixel present
	input wire logic [6:0] char_color, // Character colour word
	input wire logic char_second_aux_output, // Second aux from other on-screen content
	input wire logic int_ack_block, // Controller accepted block-end request
	input wire logic int_ack_overlay, // Controller accepted overlay-end request
	output logic block_end_interrupt, // Block-end request pending
	output logic overlay_end_interrupt, // Overlay-end request pending
	output logic [6:0] color_word, // Colour word to display
	output logic pal_valid, // Overlay palette pixel this dot
	output logic [3:0] pal_index, // Overlay palette index
	output logic first_aux_output, // Blank or first aux colour
	output logic second_aux_output // Second aux colour
);
	// ==========================================================
	// State
	typedef struct packed {
		logic hs_m, hs_s, hs_d, vs_m, vs_s, vs_d;
		logic [11:0] h_cnt;
		logic [9:0] line;
		logic [7:0] sp_ctl, c1, c2, c3;
		logic [9:0] tb, bb, lb, rb;
		logic [6:0] raster;
		logic [10:0] hs1, hs2;
		logic [9:0] vs1, vs2;
		logic [7:0] psel;
		logic blk_flag, spr_flag, lay_d, seen_on;
		logic [1:0] vact_d;
		logic [31:0] rdata;
		logic [6:0] color;
		logic pv;
		logic [3:0] pidx;
		logic aux1, aux2;
	} state_s;

	state_s r, n;
	logic [31:0] font_mem [0:255];
	logic hs_rise, vs_rise, sync_blank, font_sel;
	logic lay_act, lay_fall, sw_clr_blk, sw_clr_spr;
	logic v_in, h_in, vwin, vblank, hwin, hblank, win_ok, second_aux_output_ok, blank_area;
	logic [1:0] vis, vact, en;
	logic [3:0] pidx [2];
	logic [10:0] hs_a [2];
	logic [9:0] vs_a [2];
	logic pick2;
	logic [1:0] ws, vsh;

	// ==========================================================
	// Shared decode
	assign hs_rise = r.hs_s & ~r.hs_d;
	assign vs_rise = r.vs_s & ~r.vs_d;
	assign sync_blank = r.hs_s | r.vs_s;
	assign font_sel = reg_addr[11:10] == osd_overlay_pkg::FONT_REGION;
	assign hs_a[0] = r.hs1;
	assign hs_a[1] = r.hs2;
	assign vs_a[0] = r.vs1;
	assign vs_a[1] = r.vs2;
	assign en[0] = r.sp_ctl[osd_overlay_pkg::SC_EN1];
	assign en[1] = r.sp_ctl[osd_overlay_pkg::SC_EN2];
	// Dot width shift: predivide ratio plus two-dot size
	assign ws = {1'b0, r.sp_ctl[osd_overlay_pkg::SC_PREDIV]} + {1'b0, r.sp_ctl[osd_overlay_pkg::SC_SIZE_HI]};
	// Row height in half lines as a shift: 1/2H, 1H, 1H, 2H, doubled in double-rate scan
	always_comb begin
		unique case (r.sp_ctl[osd_overlay_pkg::SC_SIZE_HI:osd_overlay_pkg::SC_SIZE_LO])
			2'b00: vsh = 2'd0;
			2'b01: vsh = 2'd1;
			2'b10: vsh = 2'd1;
			2'b11: vsh = 2'd2;
		endcase
	end

	// ==========================================================
	// Per-character overlay pipeline
	generate
		for (genvar c = 0; c < 2; c++) begin : g_ovl
			logic [9:0] vstart, lc;
			logic [10:0] row2;
			logic [4:0] row;
			logic [11:0] hstart, hd, hcol;
			logic [6:0] col;
			logic hact;
			logic [3:0] bits;
			// Double-rate scan doubles the start line
			assign vstart = r.c1[osd_overlay_pkg::C1_BISCAN] ? {vs_a[c][8:0], 1'b0} : vs_a[c];
			assign lc = r.line - vstart;
			// Half-line count shifted by dot height; extra shift in double-rate scan
			assign row2 = ({lc, 1'b0} >> vsh) >> r.c1[osd_overlay_pkg::C1_BISCAN];
			assign row = row2[4:0];
			assign vact[c] = (r.line >= vstart) && (row2 < {6'h00, osd_overlay_pkg::FONT_ROWS});
			assign hstart = {hs_a[c], 1'b0};
			assign hd = r.h_cnt - hstart;
			// Full-width column count, so a long line cannot wrap back into the font
			assign hcol = hd >> ws;
			assign col = hcol[6:0];
			assign hact = (r.h_cnt >= hstart) && (hcol < 12'h020);
			for (genvar p = 0; p < 4; p++) begin : g_pl
				// Font word index is {character, plane, row}
				localparam logic [2:0] SEL = 3'(c * 4 + p);
				assign bits[p] = font_mem[{SEL, row}][col[4:0]];
			end
			assign pidx[c] = bits & r.psel[c*4 +: 4];
			assign vis[c] = en[c] & vact[c] & hact & (|pidx[c]);
		end
	endgenerate

	// Larger vertical start wins; a tie keeps overlay 1
	assign pick2 = vis[1] & (~vis[0] | (r.vs2 > r.vs1));

	// ==========================================================
	// Window and blank areas
	assign v_in = (r.line >= r.tb) && (r.line < r.bb);
	assign h_in = (r.h_cnt[11:2] >= r.lb) && (r.h_cnt[11:2] < r.rb);
	assign vwin = r.c1[osd_overlay_pkg::C1_VAREA_ON] & ~r.c2[osd_overlay_pkg::C2_VBLANK_SEL];
	assign vblank = r.c1[osd_overlay_pkg::C1_VAREA_ON] & r.c2[osd_overlay_pkg::C2_VBLANK_SEL];
	assign hwin = r.c2[osd_overlay_pkg::C2_HAREA_ON] & ~r.c2[osd_overlay_pkg::C2_HBLANK_SEL];
	assign hblank = r.c2[osd_overlay_pkg::C2_HAREA_ON] & r.c2[osd_overlay_pkg::C2_HBLANK_SEL];
	// Window only limits modes enabled in control 3; second aux is limited in all modes
	assign second_aux_output_ok = (~vwin | v_in) & (~hwin | h_in);
	assign win_ok = second_aux_output_ok | ~(|(disp_mode & r.c3[osd_overlay_pkg::C3_MODE_LO +: 3]));
	// Blank is never driven inside sync intervals
	assign blank_area = ((vblank & ~v_in) | (hblank & ~h_in)) & ~sync_blank;

	// ==========================================================
	// Block-end event: selected layer leaves its block
	assign lay_act = r.c2[osd_overlay_pkg::C2_INT_LAYER2] ? blk_active_l2 : blk_active_l1;
	// Overlapping blocks keep the active level high, so only one fall occurs
	assign lay_fall = r.lay_d & ~lay_act;
	assign sw_clr_blk = reg_wr && reg_addr == osd_overlay_pkg::ADDR_STATUS && reg_wdata[osd_overlay_pkg::ST_BLOCK];
	assign sw_clr_spr = reg_wr && reg_addr == osd_overlay_pkg::ADDR_STATUS && reg_wdata[osd_overlay_pkg::ST_OVERLAY];

	// ==========================================================
	// Font memory, written through the register port
	always_ff @(posedge ref_clk) begin
		if (reg_wr && font_sel) begin
			font_mem[reg_addr[9:2]] <= reg_wdata;
		end
	end

	// ==========================================================
	// Next state
	always_comb begin
		n = r;
		// Two-stage synchronisers, then a delayed copy for edges
		n.hs_m = hsync_pin;
		n.hs_s = r.hs_m;
		n.hs_d = r.hs_s;
		n.vs_m = vsync_pin;
		n.vs_s = r.vs_m;
		n.vs_d = r.vs_s;
		n.h_cnt = hs_rise ? 12'h000 : r.h_cnt + 12'h001;
		if (vs_rise) begin
			n.line = 10'h000;
		end else if (hs_rise) begin
			n.line = r.line + 10'h001;
		end
		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				osd_overlay_pkg::ADDR_SPRITE_CTL: n.sp_ctl = {3'h0, reg_wdata[4:0]};
				osd_overlay_pkg::ADDR_CTRL1: n.c1 = reg_wdata[7:0];
				osd_overlay_pkg::ADDR_CTRL2: n.c2 = reg_wdata[7:0];
				osd_overlay_pkg::ADDR_CTRL3: n.c3 = reg_wdata[7:0];
				osd_overlay_pkg::ADDR_TOP: n.tb = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_BOTTOM: n.bb = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_LEFT: n.lb = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_RIGHT: n.rb = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_RASTER: n.raster = reg_wdata[6:0];
				osd_overlay_pkg::ADDR_HPOS1: n.hs1 = reg_wdata[10:0];
				osd_overlay_pkg::ADDR_VPOS1: n.vs1 = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_HPOS2: n.hs2 = reg_wdata[10:0];
				osd_overlay_pkg::ADDR_VPOS2: n.vs2 = reg_wdata[9:0];
				osd_overlay_pkg::ADDR_PSEL: n.psel = reg_wdata[7:0];
				default: n.psel = r.psel;
			endcase
		end
		// Reads answer next cycle; unmapped reads give zero
		n.rdata = 32'h0000_0000;
		if (reg_rd) begin
			if (font_sel) begin
				n.rdata = font_mem[reg_addr[9:2]];
			end else begin
				unique case (reg_addr)
					osd_overlay_pkg::ADDR_SPRITE_CTL: n.rdata = {24'h00_0000, r.sp_ctl};
					osd_overlay_pkg::ADDR_CTRL1: n.rdata = {24'h00_0000, r.c1};
					osd_overlay_pkg::ADDR_CTRL2: n.rdata = {24'h00_0000, r.c2};
					osd_overlay_pkg::ADDR_CTRL3: n.rdata = {24'h00_0000, r.c3};
					osd_overlay_pkg::ADDR_TOP: n.rdata = {22'h00_0000, r.tb};
					osd_overlay_pkg::ADDR_BOTTOM: n.rdata = {22'h00_0000, r.bb};
					osd_overlay_pkg::ADDR_LEFT: n.rdata = {22'h00_0000, r.lb};
					osd_overlay_pkg::ADDR_RIGHT: n.rdata = {22'h00_0000, r.rb};
					osd_overlay_pkg::ADDR_RASTER: n.rdata = {25'h000_0000, r.raster};
					osd_overlay_pkg::ADDR_HPOS1: n.rdata = {21'h00_0000, r.hs1};
					osd_overlay_pkg::ADDR_VPOS1: n.rdata = {22'h00_0000, r.vs1};
					osd_overlay_pkg::ADDR_HPOS2: n.rdata = {21'h00_0000, r.hs2};
					osd_overlay_pkg::ADDR_VPOS2: n.rdata = {22'h00_0000, r.vs2};
					osd_overlay_pkg::ADDR_PSEL: n.rdata = {24'h00_0000, r.psel};
					osd_overlay_pkg::ADDR_STATUS: n.rdata = {30'h0000_0000, r.spr_flag, r.blk_flag};
					default: n.rdata = 32'h0000_0000;
				endcase
			end
		end
		// Block-end request; off blocks are never marked as seen, window is not consulted
		n.lay_d = lay_act;
		n.seen_on = lay_act & (r.seen_on | ~blk_off);
		if (int_ack_block | sw_clr_blk) begin
			n.blk_flag = 1'b0;
		end
		if (lay_fall & r.seen_on) begin
			n.blk_flag = 1'b1;
		end
		// Overlay-end request on last row leaving the scan; set beats clear
		n.vact_d = vact;
		if (int_ack_overlay | sw_clr_spr) begin
			n.spr_flag = 1'b0;
		end
		if (|(r.vact_d & ~vact & en)) begin
			n.spr_flag = 1'b1;
		end
		// Output priority: overlay, then windowed characters, then raster
		n.pv = 1'b0;
		n.pidx = 4'h0;
		n.aux1 = blank_area;
		n.aux2 = char_valid & char_second_aux_output & second_aux_output_ok;
		n.color = 7'h00;
		if (|vis) begin
			n.pv = 1'b1;
			n.pidx = pick2 ? pidx[1] : pidx[0];
		end else if (char_valid & win_ok) begin
			n.color = char_color;
			n.aux1 = blank_area | char_color[osd_overlay_pkg::RC_FIRST_AUX_OUTPUT];
		end else if (~blank_area & ~sync_blank) begin
			// Raster sits under everything and is hidden in blanked areas
			n.color = r.raster;
			n.aux1 = r.raster[osd_overlay_pkg::RC_FIRST_AUX_OUTPUT];
			n.aux2 = n.aux2 | r.raster[osd_overlay_pkg::RC_SECOND_AUX_OUTPUT];
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= '0;
			r.sp_ctl <= osd_overlay_pkg::SPRITE_CTL_RESET;
			r.c1 <= osd_overlay_pkg::CTRL_RESET;
			r.c2 <= osd_overlay_pkg::CTRL_RESET;
			r.c3 <= osd_overlay_pkg::CTRL_RESET;
			r.raster <= osd_overlay_pkg::RASTER_RESET;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from flops
	assign reg_rdata = r.rdata;
	assign block_end_interrupt = r.blk_flag;
	assign overlay_end_interrupt = r.spr_flag;
	assign color_word = r.color;
	assign pal_valid = r.pv;
	assign pal_index = r.pidx;
	assign first_aux_output = r.aux1;
	assign second_aux_output = r.aux2;

	// ==========================================================
	// Assertions
	property p_blk_set;
		@(posedge ref_clk) disable iff (rst) (lay_fall && r.seen_on) |=> block_end_interrupt;
	endproperty
	a_blk_set: assert property (p_blk_set) else $error("block-end request missing");

	property p_blk_off;
		@(posedge ref_clk) disable iff (rst)
			(lay_fall && !r.seen_on && !r.blk_flag) |=> !block_end_interrupt;
	endproperty
	a_blk_off: assert property (p_blk_off) else $error("request from off block");

	property p_layer;
		@(posedge ref_clk) disable iff (rst)
			(r.c2[osd_overlay_pkg::C2_INT_LAYER2] && $fell(blk_active_l1) && !lay_fall && !r.blk_flag)
				|=> !block_end_interrupt;
	endproperty
	a_layer: assert property (p_layer) else $error("wrong layer raised request");

	property p_spr_set;
		@(posedge ref_clk) disable iff (rst) (|(r.vact_d & ~vact & en)) |=> overlay_end_interrupt;
	endproperty
	a_spr_set: assert property (p_spr_set) else $error("overlay-end request missing");

	property p_hold;
		@(posedge ref_clk) disable iff (rst)
			(block_end_interrupt && !int_ack_block && !sw_clr_blk) |=> block_end_interrupt [*1];
	endproperty
	a_hold: assert property (p_hold) else $error("pending request lost");

	property p_prio;
		@(posedge ref_clk) disable iff (rst) (vis == 2'b11 && r.vs2 > r.vs1) |=> pal_index == $past(pidx[1]);
	endproperty
	a_prio: assert property (p_prio) else $error("overlay priority wrong");

	property p_ovl_nowin;
		@(posedge ref_clk) disable iff (rst) (|vis) |=> (pal_valid && color_word == 7'h00);
	endproperty
	a_ovl_nowin: assert property (p_ovl_nowin) else $error("overlay not shown");

	property p_no_second_aux_output;
		@(posedge ref_clk) disable iff (rst) ((|vis) && !(char_valid && char_second_aux_output)) |=> !second_aux_output;
	endproperty
	a_no_second_aux_output: assert property (p_no_second_aux_output) else $error("overlay drove second aux");

	property p_sync_blank;
		@(posedge ref_clk) disable iff (rst) (sync_blank && !char_valid && !(|vis)) |=> !first_aux_output;
	endproperty
	a_sync_blank: assert property (p_sync_blank) else $error("blank in sync interval");

	// Second aux is cut outside the window even where characters still show
	property p_second_aux_output_win;
		@(posedge ref_clk) disable iff (rst)
			(char_valid && win_ok && !second_aux_output_ok && !(|vis)) |=> !second_aux_output;
	endproperty
	a_second_aux_output_win: assert property (p_second_aux_output_win) else $error("second aux outside window");

	property p_blank_raster;
		@(posedge ref_clk) disable iff (rst)
			(blank_area && !char_valid && !(|vis)) |=> (first_aux_output && color_word == 7'h00);
	endproperty
	a_blank_raster: assert property (p_blank_raster) else $error("raster in blanked area");

	c_blk: cover property (@(posedge ref_clk) disable iff (rst) $rose(block_end_interrupt));
	c_spr: cover property (@(posedge ref_clk) disable iff (rst) $rose(overlay_end_interrupt));
	c_both: cover property (@(posedge ref_clk) disable iff (rst) vis == 2'b11);
	c_blank: cover property (@(posedge ref_clk) disable iff (rst) blank_area);
endmodule : osd_overlay_window_sprite
`default_nettype wire

//--- testbench/video_timing_model.sv
// Video timing source standing at the display side of the overlay block.
// Assumes one clock; sync levels are high inside the sync intervals.
`default_nettype none
module video_timing_model #(
	parameter int LINE_CYC = 64, // Clocks per line
	parameter int SYNC_CYC = 8, // Clocks of horizontal sync
	parameter int FRAME_LINES = 60 // Lines per frame, first two in vertical sync
) (
	input wire logic ref_clk, // Bench clock
	input wire logic run, // Frames run while high
	output logic hsync_pin, // Horizontal sync, high in interval
	output logic vsync_pin // Vertical sync, high in interval
);
	timeunit 1ns;
	timeprecision 100ps;
	int h_cnt = 0;
	int v_cnt = 0;
	// ==========================================================
	// Line and frame counters
	// Held at zero while stopped so a run always opens on a fresh frame
	always @(posedge ref_clk) begin
		if (!run) begin
			h_cnt <= 0;
			v_cnt <= 0;
		end else if (h_cnt == LINE_CYC - 1) begin
			h_cnt <= 0;
			v_cnt <= (v_cnt == FRAME_LINES - 1) ? 0 : v_cnt + 1;
		end else begin
			h_cnt <= h_cnt + 1;
		end
	end
	// Sync levels; both rest low when stopped
	assign hsync_pin = run && (h_cnt < SYNC_CYC);
	assign vsync_pin = run && (v_cnt < 2);
endmodule : video_timing_model
`default_nettype wire

//--- testbench/test_osd_overlay_window_sprite.sv
// Self-checking bench for the overlay, window, blank, raster and interrupt block.
// Assumes the package, the design and the video timing model are compiled before it.
`default_nettype none
module test_osd_overlay_window_sprite;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r;} row_s;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic hsync_pin, vsync_pin, pal_valid, first_aux_output, second_aux_output;
	logic block_end_interrupt, overlay_end_interrupt;
	logic run = 1'h0;
	logic blk_active_l1 = 1'h0;
	logic blk_active_l2 = 1'h0;
	logic blk_off = 1'h0;
	logic [2:0] disp_mode = 3'h2;
	logic char_valid = 1'h0;
	logic [6:0] char_color = 7'h2A;
	logic char_second_aux_output = 1'h0;
	logic int_ack_block = 1'h0;
	logic int_ack_overlay = 1'h0;
	logic [6:0] color_word;
	logic [3:0] pal_index;
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	// Register rows: address, written word, word read back
	row_s rows [13] = '{
		'{osd_overlay_pkg::ADDR_SPRITE_CTL, 32'hFFFF_FFEE, 32'h0000_000E},
		'{osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0023, 32'h0000_0023},
		'{osd_overlay_pkg::ADDR_CTRL2, 32'h0000_00F0, 32'h0000_00F0},
		'{osd_overlay_pkg::ADDR_CTRL3, 32'h0000_00E0, 32'h0000_00E0},
		'{osd_overlay_pkg::ADDR_TOP, 32'h0000_FFFF, 32'h0000_03FF},
		'{osd_overlay_pkg::ADDR_BOTTOM, 32'h0000_0155, 32'h0000_0155},
		'{osd_overlay_pkg::ADDR_LEFT, 32'h0000_02AA, 32'h0000_02AA},
		'{osd_overlay_pkg::ADDR_RIGHT, 32'h0000_0123, 32'h0000_0123},
		'{osd_overlay_pkg::ADDR_RASTER, 32'h0000_00FF, 32'h0000_007F},
		'{osd_overlay_pkg::ADDR_HPOS1, 32'h0000_07FF, 32'h0000_07FF},
		'{osd_overlay_pkg::ADDR_VPOS2, 32'h0000_FFFF, 32'h0000_03FF},
		'{osd_overlay_pkg::ADDR_PSEL, 32'h0000_00A5, 32'h0000_00A5},
		'{12'h03C, 32'hFFFF_FFFF, 32'h0000_0000}};
	always #2 ref_clk = ~ref_clk;
	osd_overlay_window_sprite dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.hsync_pin, .vsync_pin, .blk_active_l1, .blk_active_l2, .blk_off, .disp_mode, .char_valid,
		.char_color, .char_second_aux_output, .int_ack_block, .int_ack_overlay, .block_end_interrupt,
		.overlay_end_interrupt, .color_word, .pal_valid, .pal_index, .first_aux_output, .second_aux_output);
	video_timing_model #(.LINE_CYC(64), .SYNC_CYC(8), .FRAME_LINES(60)) video_u (.ref_clk, .run,
		.hsync_pin, .vsync_pin);
	// ==========================================================
	// Closing report and hang guard
	task automatic give_verdict;
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	// Four frames, part of a fifth and the setup fit well below this ceiling
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ==========================================================
	// Compare and bus tasks
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk7(input logic [6:0] got, input logic [6:0] exp);
		chk32({25'h0, got}, {25'h0, exp});
	endtask : chk7
	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1;
		chk32(reg_rdata, exp);
	endtask : rdchk
	// One block on the chosen layer, then a few cycles for the flag
	task automatic blk(input logic l2, input logic off, input int n);
		@(posedge ref_clk);
		blk_active_l1 <= ~l2;
		blk_active_l2 <= l2;
		blk_off <= off;
		repeat (n) @(posedge ref_clk);
		blk_active_l1 <= 1'h0;
		blk_active_l2 <= 1'h0;
		blk_off <= 1'h0;
		cyc(4);
	endtask : blk
	task automatic ack(input logic ovl);
		@(posedge ref_clk);
		int_ack_block <= ~ovl;
		int_ack_overlay <= ovl;
		@(posedge ref_clk);
		int_ack_block <= 1'h0;
		int_ack_overlay <= 1'h0;
		cyc(1);
	endtask : ack
	// Overlay-end flag seen at line n of a fresh frame
	task automatic ovl_at(input int n, input logic exp);
		@(posedge vsync_pin);
		ack(1'h1);
		repeat (n) @(posedge hsync_pin);
		cyc(6);
		chk1(overlay_end_interrupt, exp);
	endtask : ovl_at
	task automatic pix(input logic v);
		@(posedge ref_clk);
		char_valid <= v;
		cyc(3);
	endtask : pix
	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'h0;
		cyc(1);
		chk1(block_end_interrupt, 1'h0);
		chk7(color_word, 7'h00);
		foreach (rows[i]) begin
			rdchk(rows[i].a, 32'h0000_0000);
			wr(rows[i].a, rows[i].w);
			rdchk(rows[i].a, rows[i].r);
			wr(rows[i].a, 32'h0000_0000);
		end
		blk(1'h0, 1'h0, 6);
		chk1(block_end_interrupt, 1'h1);
		rdchk(osd_overlay_pkg::ADDR_STATUS, 32'h0000_0001);
		ack(1'h0);
		chk1(block_end_interrupt, 1'h0);
		blk(1'h1, 1'h0, 6);
		chk1(block_end_interrupt, 1'h0);
		wr(osd_overlay_pkg::ADDR_CTRL2, 32'h0000_0080);
		blk(1'h0, 1'h0, 6);
		chk1(block_end_interrupt, 1'h0);
		blk(1'h1, 1'h0, 6);
		chk1(block_end_interrupt, 1'h1);
		wr(osd_overlay_pkg::ADDR_STATUS, 32'h0000_0001);
		cyc(1);
		chk1(block_end_interrupt, 1'h0);
		blk(1'h1, 1'h1, 6);
		chk1(block_end_interrupt, 1'h0);
		blk(1'h1, 1'h0, 40);
		chk1(block_end_interrupt, 1'h1);
		ack(1'h0);
		cyc(8);
		chk1(block_end_interrupt, 1'h0);
		wr(osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0021);
		wr(osd_overlay_pkg::ADDR_CTRL2, 32'h0000_0090);
		wr(osd_overlay_pkg::ADDR_CTRL3, 32'h0000_00E0);
		disp_mode <= 3'h1;
		blk(1'h1, 1'h0, 6);
		chk1(block_end_interrupt, 1'h1);
		ack(1'h0);
		disp_mode <= 3'h2;
		wr(osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0000);
		wr(osd_overlay_pkg::ADDR_CTRL2, 32'h0000_0030);
		wr(osd_overlay_pkg::ADDR_LEFT, 32'h0000_0100);
		wr(osd_overlay_pkg::ADDR_RIGHT, 32'h0000_03FF);
		wr(osd_overlay_pkg::ADDR_RASTER, 32'h0000_0055);
		run <= 1'h1;
		@(negedge vsync_pin);
		@(negedge hsync_pin);
		cyc(8);
		chk7(color_word, 7'h00);
		chk1(first_aux_output, 1'h1);
		pix(1'h1);
		chk7(color_word, 7'h2A);
		pix(1'h0);
		@(posedge hsync_pin);
		cyc(5);
		chk1(first_aux_output, 1'h0);
		wr(osd_overlay_pkg::ADDR_CTRL2, 32'h0000_0000);
		@(negedge hsync_pin);
		cyc(8);
		chk7(color_word, 7'h55);
		chk1(second_aux_output, 1'h1);
		pix(1'h1);
		chk7(color_word, 7'h2A);
		chk1(first_aux_output, 1'h1);
		pix(1'h0);
		chk1(overlay_end_interrupt, 1'h0);
		wr(osd_overlay_pkg::ADDR_VPOS1, 32'h0000_0002);
		wr(osd_overlay_pkg::ADDR_HPOS1, 32'h0000_0004);
		wr(osd_overlay_pkg::ADDR_SPRITE_CTL, 32'h0000_0005);
		ovl_at(30, 1'h1);
		wr(osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0002);
		ovl_at(30, 1'h0);
		ovl_at(50, 1'h1);
		// Both overlays on lines 2..21 and 3..22, dots 8..39; unwritten planes masked off
		for (int i = 0; i < 20; i++) begin
			wr(12'h400 + 12'(4 * i), 32'hFFFF_FFFF);
			wr(12'h680 + 12'(4 * i), 32'hFFFF_FFFF);
		end
		wr(osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0000);
		wr(osd_overlay_pkg::ADDR_CTRL3, 32'h0000_0000);
		wr(osd_overlay_pkg::ADDR_PSEL, 32'h0000_0021);
		wr(osd_overlay_pkg::ADDR_HPOS2, 32'h0000_0004);
		wr(osd_overlay_pkg::ADDR_VPOS2, 32'h0000_0003);
		wr(osd_overlay_pkg::ADDR_SPRITE_CTL, 32'h0000_0015);
		char_valid <= 1'h1;
		char_second_aux_output <= 1'h1;
		@(posedge vsync_pin);
		repeat (10) @(posedge hsync_pin);
		// Sync and output delay are four cycles: cyc(24) shows dot 20, cyc(48) dot 44
		cyc(24);
		chk1(pal_valid, 1'h1);
		chk7({3'h0, pal_index}, 7'h02);
		chk7(color_word, 7'h00);
		chk1(second_aux_output, 1'h1);
		cyc(24);
		chk1(pal_valid, 1'h0);
		chk7(color_word, 7'h2A);
		wr(osd_overlay_pkg::ADDR_VPOS2, 32'h0000_0002);
		@(posedge hsync_pin);
		cyc(24);
		chk7({3'h0, pal_index}, 7'h01);
		wr(osd_overlay_pkg::ADDR_CTRL1, 32'h0000_0021);
		@(posedge hsync_pin);
		cyc(24);
		chk1(pal_valid, 1'h1);
		cyc(24);
		chk7(color_word, 7'h2A);
		chk1(second_aux_output, 1'h0);
		wr(osd_overlay_pkg::ADDR_CTRL3, 32'h0000_00E0);
		@(posedge hsync_pin);
		cyc(48);
		chk7(color_word, 7'h55);
		wr(osd_overlay_pkg::ADDR_SPRITE_CTL, 32'h0000_0017);
		@(posedge hsync_pin);
		cyc(48);
		chk1(pal_valid, 1'h1);
		chk1(overlay_end_interrupt, 1'h1);
		// Reset in mid-run drops pending requests and settings
		@(posedge ref_clk);
		rst <= 1'h1;
		repeat (3) @(posedge ref_clk);
		rst <= 1'h0;
		cyc(1);
		chk1(overlay_end_interrupt, 1'h0);
		rdchk(osd_overlay_pkg::ADDR_SPRITE_CTL, 32'h0000_0000);
		give_verdict();
	end
endmodule : test_osd_overlay_window_sprite
`default_nettype wire
